// File: hw/pdc_pll_cfg.v
// Loop configuration registers behind a classic Wishbone slave.
// Assumes 32-bit bus, one clock, reference select pin from off chip.
// Notes on behaviour
// - With mode top bit set, the select pin low picks primary, high secondary.
// - With mode top bit clear, 00 holds, 01 reverts, 10/11 force a reference.
// - A bypass bit makes its reference divider divide by one.
// - The zero resistor code decodes to 883, 677, 341, 135, 10k, external, or bad for codes 9 to 15.
// - An 8-bit field sets the output loop charge pump magnitude.
// - The feedback ratio is four times the main count plus the aux count.
// - Main count seven or more accepts any aux count, ratios 28 to 255.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "pdc_map.vh"
module pdc_pll_cfg (
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [11:0] wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    input  wire        ref_sel_pin_in,
    input  wire        primary_reference_ok_in,
    output reg         use_secondary_reference_out,
    output reg         primary_div_bypass_out,
    output reg         secondary_div_bypass_out,
    output reg  [2:0]  input_loop_zero_res_out,
    output reg  [7:0]  output_loop_pump_current_out,
    output reg  [7:0]  output_loop_ratio_out,
    output reg         output_loop_pair_legal_out
);
    reg  [7:0] ref_ctrl;
    reg  [7:0] loop_zero_resistor_select;
    reg  [7:0] output_loop_pump_current;
    reg  [7:0] output_loop_feedback_counts;
    reg  [2:0] sel_sync;
    reg        sel_stable;
    wire       use_sec;
    wire [9:0] idx;
    wire       hit;
    wire       wr;
    reg  [7:0] rd_byte;
    reg  [7:0] next_ratio;
    reg        next_legal;
    reg  [2:0] next_zr;
    wire       wr_ref;
    wire       wr_zero;
    wire       wr_pump;
    wire       wr_counts;

    // Feedback ratio 4B+A; eight bits hold the largest pair exactly
    function [7:0] pdc_ratio;
        input [5:0] b_cnt;
        input [1:0] a_cnt;
        begin
            pdc_ratio = {b_cnt, 2'h0} + {6'h00, a_cnt};
        end
    endfunction

    // Pair legality; unlisted pairs are flagged, not corrected
    function pdc_pair_ok;
        input [5:0] b_cnt;
        input [1:0] a_cnt;
        begin
            case (b_cnt)
                6'h03: pdc_pair_ok = (a_cnt == 2'h0);
                6'h04: pdc_pair_ok = (a_cnt <= 2'h1);
                6'h05: pdc_pair_ok = (a_cnt <= 2'h2);
                6'h06: pdc_pair_ok = (a_cnt <= 2'h2);
                default: pdc_pair_ok = (b_cnt >= 6'h07);
            endcase
        end
    endfunction

    assign idx = wb_adr_in[11:2];
    assign hit = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr  = hit & wb_we_in & wb_sel_in[0];
    assign wr_ref    = wr & (idx == `PDC_IDX_REF_CTRL);
    assign wr_zero   = wr & (idx == `PDC_IDX_ZERO_RES);
    assign wr_pump   = wr & (idx == `PDC_IDX_PUMP_CUR);
    assign wr_counts = wr & (idx == `PDC_IDX_FB_COUNTS);

    // Three stages; a change counts once the last two agree
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_sync   <= 3'h0;
            sel_stable <= 1'b0;
        end else begin
            sel_sync <= {sel_sync[1:0], ref_sel_pin_in};
            if (sel_sync[1] == sel_sync[2]) begin
                sel_stable <= sel_sync[2];
            end
        end
    end

    pdc_ref_select u_ref_select (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .mode_in     (ref_ctrl[`PDC_MODE_HI:`PDC_MODE_LO]),
        .sel_in      (sel_stable),
        .pri_ok_in   (primary_reference_ok_in),
        .use_sec_out (use_sec)
    );

    // Ratio and legality; illegal pairs still yield 4B+A, unguaranteed
    always @* begin
        next_ratio = pdc_ratio(
            output_loop_feedback_counts[`PDC_B_HI:`PDC_B_LO],
            output_loop_feedback_counts[`PDC_A_HI:`PDC_A_LO]);
        next_legal = pdc_pair_ok(
            output_loop_feedback_counts[`PDC_B_HI:`PDC_B_LO],
            output_loop_feedback_counts[`PDC_A_HI:`PDC_A_LO]);
    end

    always @* begin
        case (loop_zero_resistor_select[3:0])
            4'h0: next_zr = `PDC_ZR_883K;
            4'h1: next_zr = `PDC_ZR_677K;
            4'h2: next_zr = `PDC_ZR_341K;
            4'h3: next_zr = `PDC_ZR_135K;
            4'h4, 4'h5, 4'h6, 4'h7: next_zr = `PDC_ZR_10K;
            4'h8: next_zr = `PDC_ZR_EXT;
            default: next_zr = `PDC_ZR_BAD;
        endcase
    end

    always @* begin
        case (idx)
            `PDC_IDX_REF_CTRL:  rd_byte = ref_ctrl;
            `PDC_IDX_ZERO_RES:  rd_byte = loop_zero_resistor_select;
            `PDC_IDX_PUMP_CUR:  rd_byte = output_loop_pump_current;
            `PDC_IDX_FB_COUNTS: rd_byte = output_loop_feedback_counts;
            `PDC_IDX_STATUS:    rd_byte = {5'h00, output_loop_pair_legal_out,
                                           sel_stable,
                                           use_secondary_reference_out};
            `PDC_IDX_NRATIO:    rd_byte = output_loop_ratio_out;
            default:            rd_byte = 8'h00;
        endcase
    end

    // One wait state: ack one cycle after the request, dropped next cycle
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_ctrl                    <= `PDC_RST_REF_CTRL;
            loop_zero_resistor_select   <= `PDC_RST_ZERO_RES;
            output_loop_pump_current    <= `PDC_RST_PUMP_CUR;
            output_loop_feedback_counts <= `PDC_RST_FB_COUNTS;
            wb_ack_out                  <= 1'b0;
            wb_dat_out                  <= 32'h00000000;
        end else begin
            wb_ack_out <= hit;
            if (hit) begin
                wb_dat_out <= {24'h000000, rd_byte};
            end
            // Bit 5 of ref_ctrl and bits 7:4 of the zero select are dropped so they read back zero
            if (wr_ref) begin
                ref_ctrl <= wb_dat_in[7:0] & 8'hDF;
            end
            if (wr_zero) begin
                loop_zero_resistor_select <= wb_dat_in[7:0] & 8'h0F;
            end
            if (wr_pump) begin
                output_loop_pump_current <= wb_dat_in[7:0];
            end
            // Any pair is stored; legality is reported, not enforced
            if (wr_counts) begin
                output_loop_feedback_counts <= wb_dat_in[7:0];
            end
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            use_secondary_reference_out  <= 1'b0;
            primary_div_bypass_out       <= 1'b0;
            secondary_div_bypass_out     <= 1'b0;
            input_loop_zero_res_out      <= `PDC_ZR_883K;
            output_loop_pump_current_out <= `PDC_RST_PUMP_CUR;
            output_loop_ratio_out        <= 8'h00;
            output_loop_pair_legal_out   <= 1'b0;
        end else begin
            use_secondary_reference_out  <= use_sec;
            primary_div_bypass_out   <= ref_ctrl[`PDC_BYP_PRI];
            secondary_div_bypass_out <= ref_ctrl[`PDC_BYP_SEC];
            input_loop_zero_res_out      <= next_zr;
            output_loop_pump_current_out <= output_loop_pump_current;
            output_loop_ratio_out        <= next_ratio;
            output_loop_pair_legal_out   <= next_legal;
        end
    end
endmodule // pdc_pll_cfg

// File: hw/pdc_map.vh
// Register map, field positions and reset values of the loop configuration.
// Assumes byte-wide registers on a 32-bit classic Wishbone slave.
`ifndef PDC_MAP_VH
`define PDC_MAP_VH
// Printed offsets are register indexes; byte address is four times these
`define PDC_IDX_REF_CTRL      10'h01C
`define PDC_IDX_ZERO_RES      10'h01D
`define PDC_IDX_PUMP_CUR      10'h0F0
`define PDC_IDX_FB_COUNTS     10'h0F1
`define PDC_IDX_STATUS        10'h0F8
`define PDC_IDX_NRATIO        10'h0F9
`define PDC_RST_REF_CTRL      8'h00
`define PDC_RST_ZERO_RES      8'h00
`define PDC_RST_PUMP_CUR      8'h00
`define PDC_RST_FB_COUNTS     8'hC7
`define PDC_MODE_HI           4
`define PDC_MODE_LO           2
`define PDC_BYP_SEC           1
`define PDC_BYP_PRI           0
`define PDC_A_HI              7
`define PDC_A_LO              6
`define PDC_B_HI              5
`define PDC_B_LO              0
`define PDC_ZR_883K           3'h0
`define PDC_ZR_677K           3'h1
`define PDC_ZR_341K           3'h2
`define PDC_ZR_135K           3'h3
`define PDC_ZR_10K            3'h4
`define PDC_ZR_EXT            3'h5
`define PDC_ZR_BAD            3'h6
`endif

// File: hw/pdc_ref_select.v
// Reference choice from the mode field and the synchronised select pin.
// Assumes sel_in is already on clk_in; keeps the last pick as state.
`timescale 1ns/1ps
`include "pdc_map.vh"
module pdc_ref_select (
    input  wire       clk_in,
    input  wire       rstn_in,
    input  wire [2:0] mode_in,
    input  wire       sel_in,
    input  wire       pri_ok_in,
    output reg        use_sec_out
);
    reg next_use_sec;
    always @* begin
        next_use_sec = use_sec_out;
        if (mode_in[2]) begin
            next_use_sec = sel_in;
        end else begin
            case (mode_in[1:0])
                2'h0: next_use_sec = use_sec_out;
                2'h1: next_use_sec = ~pri_ok_in; // Revert when primary good
                2'h2: next_use_sec = 1'b0;
                2'h3: next_use_sec = 1'b1;
                default: next_use_sec = use_sec_out;
            endcase
        end
    end
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            use_sec_out <= 1'b0;
        end else begin
            use_sec_out <= next_use_sec;
        end
    end
endmodule // pdc_ref_select

// File: tb/pdc_pll_cfg_properties.sv
// Checker of the loop configuration block, bound to its top module.
// Assumes writes held until ack and a single clock domain.
`timescale 1ns/1ps
module pdc_pll_cfg_chk (
    input logic        clk_in,
    input logic        rstn_in,
    input logic        wb_cyc_in,
    input logic        wb_stb_in,
    input logic        wb_we_in,
    input logic [11:0] wb_adr_in,
    input logic [3:0]  wb_sel_in,
    input logic [31:0] wb_dat_in,
    input logic        wb_ack_out,
    input logic        use_secondary_reference_out,
    input logic        primary_div_bypass_out,
    input logic        secondary_div_bypass_out,
    input logic [2:0]  input_loop_zero_res_out,
    input logic [7:0]  output_loop_pump_current_out,
    input logic [7:0]  output_loop_ratio_out,
    input logic        output_loop_pair_legal_out
);
    // Write seen in its ack cycle; derived outputs land one edge later, the reference pick two edges later
    wire       wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out
                    && wb_sel_in[0];
    wire [9:0] ix = wb_adr_in[11:2];
    wire [7:0] d  = wb_dat_in[7:0];
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out) else $error("no ack");
    ratio_form_a: assert property (
        wr && ix == 10'h0F1 && d[5:0] >= 6'h07 |=> output_loop_ratio_out ==
        {$past(d[5:0]), $past(d[7:6])}) else $error("ratio wrong");
    pair_legal_a: assert property (
        wr && ix == 10'h0F1 && d[5:0] >= 6'h07 |=> output_loop_pair_legal_out)
        else $error("legal pair refused");
    pump_code_a: assert property (
        wr && ix == 10'h0F0 |=> output_loop_pump_current_out == $past(d))
        else $error("pump wrong");
    zres_decode_a: assert property (
        wr && ix == 10'h01D && !d[3] |=> input_loop_zero_res_out ==
        ($past(d[2]) ? 3'h4 : {1'b0, $past(d[1:0])})) else $error("zero bad");
    bypass_bits_a: assert property (
        wr && ix == 10'h01C |=> {secondary_div_bypass_out,
        primary_div_bypass_out} == $past(d[1:0])) else $error("bypass bad");
    mode_force_a: assert property (
        wr && ix == 10'h01C && d[4:3] == 2'h1 |=> ##1
        use_secondary_reference_out == $past(d[2], 2)) else $error("force bad");
endmodule // pdc_pll_cfg_chk

bind pdc_pll_cfg pdc_pll_cfg_chk chk_u (.clk_in, .rstn_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out,
    .use_secondary_reference_out, .primary_div_bypass_out,
    .secondary_div_bypass_out, .input_loop_zero_res_out,
    .output_loop_pump_current_out, .output_loop_ratio_out,
    .output_loop_pair_legal_out);

// File: tb/tb.sv
// Self-checking bench for the loop configuration block.
// Assumes a one-cycle ack per Wishbone request; sel fixed to low lane.
`timescale 1ns/1ps
module tb;
    logic        clk_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, pin = 1'b0, ok = 1'b0, ack, sec, bp, bs, legal;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [2:0]  zres;
    logic [7:0]  pump, ratio, q;
    // Mode, ok, pin, expected secondary pick
    logic [5:0]  mt [8] = '{6'h19, 6'h01, 6'h10, 6'h00, 6'h09, 6'h0C,
                            6'h38, 6'h3B};
    int          fails = 0, cmp_count = 0, i, b, a, n;
    always #50 clk_in = ~clk_in;
    pdc_pll_cfg dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .ref_sel_pin_in(pin), .primary_reference_ok_in(ok),
        .use_secondary_reference_out(sec), .primary_div_bypass_out(bp),
        .secondary_div_bypass_out(bs), .input_loop_zero_res_out(zres),
        .output_loop_pump_current_out(pump), .output_loop_ratio_out(ratio),
        .output_loop_pair_legal_out(legal));
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    // Holds the request until ack is sampled; bounded wait
    task automatic wb(input logic w, input logic [9:0] x, input logic [7:0] v);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {x, 2'h0};
        wdat <= {24'h0, v};
        for (n = 0; n < 50 && ack !== 1'b1; n++)
            @(posedge clk_in);
        if (n == 50) begin
            fails++;
            tally_and_finish;
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    initial begin
        void'($urandom(18052));
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        wb(0, 10'h0F1, 8'h00);
        cmp("fb rst", 8'hC7, q);
        cmp("ratio", 8'h1F, ratio);
        for (i = 0; i < 4; i++) begin
            b = $urandom;
            wb(1, 10'h0F0, b[7:0]);
            repeat (2) @(posedge clk_in);
            cmp("pump", b[7:0], pump);
        end
        for (i = 0; i < 9; i++) begin
            wb(1, 10'h01D, 8'hF0 | i[7:0]);
            wb(0, 10'h01D, 8'h00);
            cmp("zero rd", i[7:0], q);
            cmp("zero", i == 8 ? 8'h05 : i > 3 ? 8'h04 : i[7:0], {5'h0, zres});
        end
        for (i = 0; i < 12; i++) begin
            b = i < 4 ? i + 3 : 7 + $urandom % 57;
            a = b == 3 ? 0 : b == 4 ? 1 : b < 7 ? 2 : $urandom % 4;
            wb(1, 10'h0F1, {a[1:0], b[5:0]});
            repeat (2) @(posedge clk_in);
            cmp("ratio", 8'(4 * b + a), ratio);
            cmp("legal", 8'h01, {7'h0, legal});
            wb(0, 10'h0F9, 8'h00);
            cmp("ratio rd", 8'(4 * b + a), q);
        end
        wb(1, 10'h0F1, 8'h43);
        repeat (2) @(posedge clk_in);
        cmp("illegal", 8'h00, {7'h0, legal});
        for (i = 0; i < 4; i++) begin
            wb(1, 10'h01C, i[7:0]);
            repeat (2) @(posedge clk_in);
            cmp("bypass", i[7:0], {6'h0, bs, bp});
        end
        for (i = 0; i < 8; i++) begin
            ok <= mt[i][2];
            pin <= mt[i][1];
            wb(1, 10'h01C, {3'h0, mt[i][5:3], 2'h0});
            repeat (8) @(posedge clk_in);
            cmp("ref", {7'h0, mt[i][0]}, {7'h0, sec});
        end
        wb(1, 10'h3FF, 8'hAA);
        wb(0, 10'h3FF, 8'h00);
        cmp("unmapped", 8'h00, q);
        tally_and_finish;
    end
endmodule // tb
